// [core/ptc_defs.vh]
// Register offsets, reset values and timing constants for the precision time clock
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

`define PTC_ADDR_W          9
`define PTC_OFF_CAP_HI      9'h168
`define PTC_OFF_CAP_LO      9'h16C
`define PTC_OFF_TIME_HI     9'h170
`define PTC_OFF_TIME_LO     9'h174
`define PTC_OFF_ADDEND      9'h178
`define PTC_OFF_MATCH_HI    9'h17C
`define PTC_OFF_MATCH_LO    9'h180
`define PTC_OFF_RELOAD_HI   9'h184
`define PTC_OFF_RELOAD_LO   9'h188
`define PTC_OFF_CONFIG      9'h194
`define PTC_OFF_CMD         9'h1A0
`define PTC_OFF_STATUS      9'h1A4
`define PTC_OFF_IRQ_EN      9'h1A8

`define PTC_CFG_RELOAD_BIT  0
`define PTC_CMD_SNAP_BIT    0
`define PTC_STS_MATCH_BIT   0

`define PTC_RST_WORD        32'h00000000
`define PTC_RST_CONFIG      32'h00000000
`define PTC_UNMAPPED_READ   32'h00000000

`define PTC_BASE_RATE_MHZ   100
`define PTC_CORE_RATE_MHZ   40

`endif

// [core/ptc_pair_latch.v]
// Two-half write staging: commits a 64-bit value only after both halves are written
`include "ptc_defs.vh"
module ptc_pair_latch (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Half writes
  input  wire        wr_hi,
  input  wire        wr_lo,
  input  wire [31:0] wdata,
  // Committed pair
  output reg  [63:0] pair_q,
  output reg         commit_q
);

  reg [31:0] hi_stage_q;
  reg [31:0] lo_stage_q;
  reg        hi_seen_q;
  reg        lo_seen_q;

  wire hi_now = wr_hi | hi_seen_q;
  wire lo_now = wr_lo | lo_seen_q;
  wire both   = hi_now & lo_now;

  // Stage halves; the commit pulse fires in the cycle after the second half
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hi_stage_q <= `PTC_RST_WORD;
      lo_stage_q <= `PTC_RST_WORD;
      hi_seen_q  <= 1'b0;
      lo_seen_q  <= 1'b0;
      pair_q     <= {`PTC_RST_WORD, `PTC_RST_WORD};
      commit_q   <= 1'b0;
    end else begin
      if (wr_hi) hi_stage_q <= wdata;
      if (wr_lo) lo_stage_q <= wdata;
      commit_q <= both;
      if (both) begin
        pair_q    <= {(wr_hi ? wdata : hi_stage_q), (wr_lo ? wdata : lo_stage_q)};
        hi_seen_q <= 1'b0;
        lo_seen_q <= 1'b0;
      end else begin
        hi_seen_q <= hi_now;
        lo_seen_q <= lo_now;
      end
    end
  end

endmodule // ptc_pair_latch

// [core/ptc_time_clock.v]
// Precision time clock with addend trim, input capture, snapshot read and compare
`include "ptc_defs.vh"

module ptc_time_clock #(
  parameter TICK_STEP = 1
) (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst_n,
  // Register port
  input  wire [`PTC_ADDR_W-1:0] reg_addr,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [31:0]            reg_wdata,
  output reg  [31:0]            reg_rdata_q,
  output reg                    reg_rvalid_q,
  // Capture pin
  input  wire                   stamp_in9,
  // Event outputs
  output reg                    match_irq_q,
  output reg                    match_pulse_q
);

  localparam [63:0] STEP = {32'h00000000, TICK_STEP[31:0]};

  // Decoded write strobes
  reg wr_time_hi;
  reg wr_time_lo;
  reg wr_match_hi;
  reg wr_match_lo;
  reg wr_rel_hi;
  reg wr_rel_lo;
  reg wr_addend;
  reg wr_config;
  reg wr_cmd;
  reg wr_status;
  reg wr_irq_en;

  // Write decode as an if chain; unmapped writes are dropped
  always @* begin
    wr_time_hi  = 1'b0;
    wr_time_lo  = 1'b0;
    wr_match_hi = 1'b0;
    wr_match_lo = 1'b0;
    wr_rel_hi   = 1'b0;
    wr_rel_lo   = 1'b0;
    wr_addend   = 1'b0;
    wr_config   = 1'b0;
    wr_cmd      = 1'b0;
    wr_status   = 1'b0;
    wr_irq_en   = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `PTC_OFF_TIME_HI) begin
        wr_time_hi = 1'b1;
      end else if (reg_addr == `PTC_OFF_TIME_LO) begin
        wr_time_lo = 1'b1;
      end else if (reg_addr == `PTC_OFF_ADDEND) begin
        wr_addend = 1'b1;
      end else if (reg_addr == `PTC_OFF_MATCH_HI) begin
        wr_match_hi = 1'b1;
      end else if (reg_addr == `PTC_OFF_MATCH_LO) begin
        wr_match_lo = 1'b1;
      end else if (reg_addr == `PTC_OFF_RELOAD_HI) begin
        wr_rel_hi = 1'b1;
      end else if (reg_addr == `PTC_OFF_RELOAD_LO) begin
        wr_rel_lo = 1'b1;
      end else if (reg_addr == `PTC_OFF_CONFIG) begin
        wr_config = 1'b1;
      end else if (reg_addr == `PTC_OFF_CMD) begin
        wr_cmd = 1'b1;
      end else if (reg_addr == `PTC_OFF_STATUS) begin
        wr_status = 1'b1;
      end else if (reg_addr == `PTC_OFF_IRQ_EN) begin
        wr_irq_en = 1'b1;
      end
    end
  end

  // Paired-half staging for time, target and reload
  wire [63:0] time_load;
  wire        time_commit;
  wire [63:0] match_load;
  wire        match_commit;
  wire [63:0] reload_val;

  ptc_pair_latch u_time_pair (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_hi    (wr_time_hi),
    .wr_lo    (wr_time_lo),
    .wdata    (reg_wdata),
    .pair_q   (time_load),
    .commit_q (time_commit)
  );

  ptc_pair_latch u_match_pair (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_hi    (wr_match_hi),
    .wr_lo    (wr_match_lo),
    .wdata    (reg_wdata),
    .pair_q   (match_load),
    .commit_q (match_commit)
  );

  ptc_pair_latch u_reload_pair (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_hi    (wr_rel_hi),
    .wr_lo    (wr_rel_lo),
    .wdata    (reg_wdata),
    .pair_q   (reload_val),
    .commit_q ()
  );

  // Raw half registers for read-back of written values
  reg [31:0] match_hi_rd_q;
  reg [31:0] match_lo_rd_q;
  reg [31:0] rel_hi_rd_q;
  reg [31:0] rel_lo_rd_q;
  reg [31:0] addend_q;
  reg        reload_sel_q;
  reg        irq_en_q;

  // Software-owned configuration
  always @(posedge core_clk) begin
    if (!rst_n) begin
      match_hi_rd_q <= `PTC_RST_WORD;
      match_lo_rd_q <= `PTC_RST_WORD;
      rel_hi_rd_q   <= `PTC_RST_WORD;
      rel_lo_rd_q   <= `PTC_RST_WORD;
      addend_q      <= `PTC_RST_WORD;
      reload_sel_q  <= 1'b0;
      irq_en_q      <= 1'b0;
    end else begin
      if (wr_match_hi) match_hi_rd_q <= reg_wdata;
      if (wr_match_lo) match_lo_rd_q <= reg_wdata;
      if (wr_rel_hi) rel_hi_rd_q <= reg_wdata;
      if (wr_rel_lo) rel_lo_rd_q <= reg_wdata;
      if (wr_addend) addend_q <= reg_wdata;
      if (wr_config) reload_sel_q <= reg_wdata[`PTC_CFG_RELOAD_BIT];
      if (wr_irq_en) irq_en_q <= reg_wdata[`PTC_STS_MATCH_BIT];
    end
  end

  // Accumulator with carry; the carry is the tick enable for the count
  reg  [31:0] accum_q;
  wire [32:0] accum_sum = {1'b0, accum_q} + {1'b0, addend_q};
  wire        tick      = accum_sum[32];

  reg  [63:0] time_q;

  // Live time count; a committed load beats the tick in the same cycle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      accum_q <= `PTC_RST_WORD;
      time_q  <= {`PTC_RST_WORD, `PTC_RST_WORD};
    end else begin
      accum_q <= accum_sum[31:0];
      if (time_commit) begin
        time_q <= time_load;
      end else if (tick) begin
        time_q <= time_q + STEP;
      end
    end
  end

  // Capture pin synchroniser; the second and third stages feed the edge detector
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg [63:0] cap_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      cap_q   <= {`PTC_RST_WORD, `PTC_RST_WORD};
    end else begin
      sync1_q <= stamp_in9;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q & ~sync3_q) cap_q <= time_q;
    end
  end

  // Snapshot of the count for coherent two-half reads
  reg [63:0] snap_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      snap_q <= {`PTC_RST_WORD, `PTC_RST_WORD};
    end else if (wr_cmd && reg_wdata[`PTC_CMD_SNAP_BIT]) begin
      snap_q <= time_q;
    end
  end

  // Compare target; a software commit takes priority over a match update
  reg  [63:0] match_q;
  wire        hit = (time_q == match_q);
  reg         hit_q;
  wire        match_event = hit & ~hit_q; // One event per match, not per cycle

  always @(posedge core_clk) begin
    if (!rst_n) begin
      match_q <= {`PTC_RST_WORD, `PTC_RST_WORD};
      hit_q   <= 1'b1; // Time and target both reset to zero; no false event on release
    end else begin
      hit_q <= hit;
      if (match_commit) begin
        match_q <= match_load;
      end else if (match_event) begin
        if (reload_sel_q) begin
          match_q <= reload_val;
        end else begin
          match_q <= match_q + reload_val;
        end
      end
    end
  end

  // Sticky match flag; a new event wins over a clear in the same cycle
  reg match_flag_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      match_flag_q  <= 1'b0;
      match_irq_q   <= 1'b0;
      match_pulse_q <= 1'b0;
    end else begin
      if (match_event) begin
        match_flag_q <= 1'b1;
      end else if (wr_status && reg_wdata[`PTC_STS_MATCH_BIT]) begin
        match_flag_q <= 1'b0;
      end
      match_irq_q   <= (match_flag_q | match_event) & irq_en_q;
      match_pulse_q <= match_event;
    end
  end

  // Read mux; unmapped offsets return zero
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = `PTC_UNMAPPED_READ;
    if (reg_addr == `PTC_OFF_CAP_HI) begin
      rd_mux = cap_q[63:32];
    end else if (reg_addr == `PTC_OFF_CAP_LO) begin
      rd_mux = cap_q[31:0];
    end else if (reg_addr == `PTC_OFF_TIME_HI) begin
      rd_mux = snap_q[63:32];
    end else if (reg_addr == `PTC_OFF_TIME_LO) begin
      rd_mux = snap_q[31:0];
    end else if (reg_addr == `PTC_OFF_ADDEND) begin
      rd_mux = addend_q;
    end else if (reg_addr == `PTC_OFF_MATCH_HI) begin
      rd_mux = match_hi_rd_q;
    end else if (reg_addr == `PTC_OFF_MATCH_LO) begin
      rd_mux = match_lo_rd_q;
    end else if (reg_addr == `PTC_OFF_RELOAD_HI) begin
      rd_mux = rel_hi_rd_q;
    end else if (reg_addr == `PTC_OFF_RELOAD_LO) begin
      rd_mux = rel_lo_rd_q;
    end else if (reg_addr == `PTC_OFF_CONFIG) begin
      rd_mux = {31'h00000000, reload_sel_q};
    end else if (reg_addr == `PTC_OFF_STATUS) begin
      rd_mux = {31'h00000000, match_flag_q};
    end else if (reg_addr == `PTC_OFF_IRQ_EN) begin
      rd_mux = {31'h00000000, irq_en_q};
    end
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q  <= `PTC_RST_WORD;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) reg_rdata_q <= rd_mux;
    end
  end

endmodule // ptc_time_clock

// [dv/ptc_time_clock_monitor.sv]
// Port-level assertions for the precision time clock
`include "ptc_defs.vh"
module ptc_time_clock_monitor (
  // Clock and reset
  input wire                   core_clk,
  input wire                   rst_n,
  // Register port
  input wire [`PTC_ADDR_W-1:0] reg_addr,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [31:0]            reg_wdata,
  input wire [31:0]            reg_rdata_q,
  input wire                   reg_rvalid_q,
  // Pin and events
  input wire                   stamp_in9,
  input wire                   match_irq_q,
  input wire                   match_pulse_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read answers come one cycle after the strobe
  a_read_answered: assert property (reg_rd |=> reg_rvalid_q) else $error("read not answered");
  a_no_stray_rvalid: assert property (!reg_rd |=> !reg_rvalid_q) else $error("stray read valid");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 9'h1A8 |=> reg_rdata_q == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_held: assert property ($changed(reg_rdata_q) |-> reg_rvalid_q) else $error("read data moved");
  // Equality must fall before it can rise again
  a_pulse_single: assert property (match_pulse_q |=> !match_pulse_q) else $error("double match pulse");
  a_irq_on_event: assert property ($fell(match_irq_q) |-> !match_pulse_q) else $error("irq fell on event");
  // Flag is sticky: only a register write may drop the request
  a_irq_sticky: assert property (match_irq_q && !reg_wr && !$past(reg_wr) |=> match_irq_q)
    else $error("irq dropped alone");
  a_irq_has_cause: assert property ($rose(match_irq_q) |-> match_pulse_q || $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq without cause");
endmodule // ptc_time_clock_monitor

bind ptc_time_clock ptc_time_clock_monitor ptc_time_clock_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .stamp_in9(stamp_in9), .match_irq_q(match_irq_q), .match_pulse_q(match_pulse_q));

// [dv/tb_ptc_time_clock.sv]
// Self-checking bench for the precision time clock
`include "ptc_defs.vh"
module tb_ptc_time_clock;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, stamp_in9 = 0;
  logic [8:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, r;
  wire  [31:0] reg_rdata_q;
  wire         reg_rvalid_q, match_irq_q, match_pulse_q;
  int          fails = 0, compares = 0, cyc = 0, npulse = 0;
  logic [63:0] m_w, m_time, got;
  logic [8:0]  offs[14] = '{9'h168, 9'h16C, 9'h170, 9'h174, 9'h178, 9'h17C, 9'h180, 9'h184,
                            9'h188, 9'h194, 9'h1A0, 9'h1A4, 9'h1A8, 9'h1FC};

  ptc_time_clock #(.TICK_STEP(1)) ptc_time_clock_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .stamp_in9(stamp_in9), .match_irq_q(match_irq_q), .match_pulse_q(match_pulse_q));

  always #12.5 core_clk = ~core_clk;
  // Event tally and hang guard; the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (match_pulse_q === 1'b1) npulse++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Strobes last one cycle; a gap cycle follows so no signal is set twice at once
  task automatic wr(logic [8:0] a, logic [31:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1;
    cy(1);
    reg_wr = 0;
    cy(1);
  endtask
  task automatic rd(logic [8:0] a, output logic [31:0] d);
    reg_addr = a; reg_rd = 1;
    cy(1);
    reg_rd = 0;
    for (int i = 0; i < 3 && reg_rvalid_q !== 1'b1; i++) cy(1);
    d = reg_rdata_q;
    cy(1);
  endtask
  task automatic ld(logic [8:0] a, logic [63:0] v);
    wr(a, v[63:32]);
    wr(a + 9'h004, v[31:0]);
  endtask
  task automatic snap(output logic [63:0] v);
    wr(`PTC_OFF_CMD, 32'h00000001);
    rd(`PTC_OFF_TIME_HI, v[63:32]);
    rd(`PTC_OFF_TIME_LO, v[31:0]);
  endtask
  // Run the clock at a trimmed rate for a fixed span, then stop it
  task automatic tick;
    npulse = 0;
    wr(`PTC_OFF_ADDEND, 32'h80000000);
    cy(28);
    wr(`PTC_OFF_ADDEND, 32'h00000000);
  endtask

  initial begin
    r = $urandom(9);
    cy(5);
    rst_n = 1;
    foreach (offs[i]) begin
      rd(offs[i], r);
      chk("reset value", 0, r);
    end
    $display("test reset done");
    m_w = {$urandom, $urandom};
    wr(`PTC_OFF_TIME_HI, m_w[63:32]);
    wr(`PTC_OFF_CAP_HI, 32'hFFFFFFFF);
    snap(got);
    chk("half time load", 0, got);
    wr(`PTC_OFF_TIME_LO, m_w[31:0]);
    snap(got);
    chk("time load", m_w, got);
    $display("test load done");
    stamp_in9 = 1;
    cy(6);
    stamp_in9 = 0;
    rd(`PTC_OFF_CAP_HI, got[63:32]);
    rd(`PTC_OFF_CAP_LO, got[31:0]);
    chk("capture", m_w, got);
    m_time = m_w + 64'h100;
    ld(`PTC_OFF_TIME_HI, m_time);
    rd(`PTC_OFF_TIME_HI, got[63:32]);
    rd(`PTC_OFF_TIME_LO, got[31:0]);
    chk("held snapshot", m_w, got);
    $display("test capture done");
    wr(`PTC_OFF_IRQ_EN, 32'h00000001);
    ld(`PTC_OFF_RELOAD_HI, 64'h0A);
    rd(`PTC_OFF_RELOAD_LO, r);
    chk("reload low", 64'h0A, r);
    npulse = 0;
    ld(`PTC_OFF_MATCH_HI, m_time);
    cy(3);
    chk("match events", 1, npulse);
    chk("irq raised", 1, match_irq_q);
    rd(`PTC_OFF_STATUS, r);
    chk("match flag", 1, r);
    wr(`PTC_OFF_STATUS, 32'h00000001);
    cy(2);
    chk("irq cleared", 0, match_irq_q);
    tick;
    snap(got);
    chk("tick window", 1, got - m_time >= 12 && got - m_time <= 17);
    chk("add events", 1, npulse);
    // Target should now sit two reload steps past the first match
    npulse = 0;
    ld(`PTC_OFF_TIME_HI, m_time + 64'h14);
    cy(3);
    chk("added target", 1, npulse);
    $display("test add mode done");
    wr(`PTC_OFF_CONFIG, 32'h00000001);
    m_time = {$urandom, $urandom} >> 1;
    ld(`PTC_OFF_RELOAD_HI, m_time + 64'h4);
    ld(`PTC_OFF_TIME_HI, m_time);
    npulse = 0;
    ld(`PTC_OFF_MATCH_HI, m_time);
    cy(3);
    chk("first event", 1, npulse);
    tick;
    chk("reload events", 1, npulse);
    $display("test reload mode done");
    tally_and_finish;
  end
endmodule // tb_ptc_time_clock
